// [bpf_pin_cfg.v]
// Purpose: pin function and pad configuration for the serial bridge
// Assumes: host writes one configuration set through cfg_wr strobe
// Notes:   only the first write is kept until reset
`include "bpf_consts.vh"
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Bit7 pull-up, bit6 pull-down, pull-up wins
// - Request/ready function codes 000 to 100
// - Carrier detect field: input, OD, PP
// - Ring indicator field incl dedicated input
// - Ring wake needs bit5 and USB attribute
// - Receive wake needs bit5 and USB attribute
// - Transmit driver: 01 open-drain, 10 push-pull
// - Serial pulls act on receive pin
// - Codes 001/101 show suspend
// - Codes 010/110 show suspend or unconfigured
// - Codes 011/111 show bus reset
// - Codes 000/100: A suspend or bus reset, B inverse of A
// - Indicator driver: 01 open-drain, 10 push-pull
// - Only the first configuration write accepted
module bpf_pin_cfg (
  input  wire       sys_clk,        // Core clock, 10 MHz
  input  wire       srst,           // Synchronous reset, active high
  input  wire       cfg_wr,         // Configuration write strobe
  input  wire [7:0] rr_cfg_in,      // Request/ready byte to write
  input  wire [7:0] cd_cfg_in,      // Carrier detect byte
  input  wire [7:0] ri_cfg_in,      // Ring indicator byte
  input  wire [7:0] sd_cfg_in,      // Serial data byte
  input  wire [7:0] ind_a_cfg_in,   // Indicator A byte
  input  wire [7:0] ind_b_cfg_in,   // Indicator B byte
  input  wire       usb_suspend,    // Bus suspended
  input  wire       usb_configured, // Device configured
  input  wire       usb_bus_reset,  // Bus reset present
  input  wire       usb_rwk_attr,   // Remote wakeup allowed by host
  input  wire       rr_gpio_out,    // GPIO level for request pin
  input  wire       rr_ded_out,     // Dedicated request level
  input  wire       cd_gpio_out,    // GPIO level for carrier pin
  input  wire       ri_gpio_out,    // GPIO level for ring pin
  input  wire       ri_pin_in,      // Ring pin from pad
  input  wire       rx_pin_in,      // Receive pin from pad
  input  wire       tx_data,        // Transmit data from UART
  output reg  [7:0] request_ready_pin_cfg,  // Stored bytes, readable
  output reg  [7:0] carrier_detect_pin_cfg,
  output reg  [7:0] ring_indicator_pin_cfg,
  output reg  [7:0] serial_data_pin_cfg,
  output reg  [7:0] bus_state_indicator_cfg_a,
  output reg  [7:0] bus_state_indicator_cfg_b,
  output reg        cfg_locked,     // A write was accepted
  output reg        rr_out,         // Request pad output
  output reg        rr_oe,          // Request pad enable
  output reg  [1:0] rr_pull,        // {up, down}
  output reg        rr_ded_sel,     // Dedicated request in use
  output reg        cd_out,         // Carrier pad output
  output reg        cd_oe,
  output reg  [1:0] cd_pull,
  output reg        ri_out,         // Ring pad output
  output reg        ri_oe,
  output reg  [1:0] ri_pull,
  output reg        ri_ded_sel,     // Ring goes to modem status
  output reg        tx_out,         // Transmit pad output
  output reg        tx_oe,
  output reg  [1:0] rx_pull,        // Pulls on receive pin
  output reg        bus_state_out_a,    // Indicator A pad
  output reg        bus_state_out_a_oe,
  output reg        bus_state_out_b,    // Indicator B pad
  output reg        bus_state_out_b_oe,
  output reg        remote_wake_req // Wake request to USB core
);
  // Pin inputs from outside: three-stage synchronisers
  reg  [2:0] ri_sync;               // Ring pin sync chain
  reg  [2:0] rx_sync;               // Receive pin sync chain
  reg        ri_stable;             // Filtered ring level
  reg        rx_stable;             // Filtered receive level
  wire [2:0] rr_fn  = request_ready_pin_cfg[`BPF_RR_FN_MSB:0];
  wire [1:0] cd_fn  = carrier_detect_pin_cfg[`BPF_FN2_MSB:0];
  wire [1:0] ri_fn  = ring_indicator_pin_cfg[`BPF_FN2_MSB:0];
  wire [1:0] sd_fn  = serial_data_pin_cfg[`BPF_FN2_MSB:0];
  wire [2:0] indicator_function_sel =
    bus_state_indicator_cfg_a[`BPF_IND_FN_MSB:`BPF_IND_FN_LSB];
  wire       wake_from_pin_enable_ri = ring_indicator_pin_cfg[`BPF_WAKE_BIT];
  wire       wake_from_pin_enable_rx = serial_data_pin_cfg[`BPF_WAKE_BIT];

  // Accept one configuration write, ignore later ones
  always @(posedge sys_clk) begin
    if (srst) begin
      request_ready_pin_cfg     <= `BPF_RST_RR;
      carrier_detect_pin_cfg    <= `BPF_RST_CD;
      ring_indicator_pin_cfg    <= `BPF_RST_RI;
      serial_data_pin_cfg       <= `BPF_RST_SD;
      bus_state_indicator_cfg_a <= `BPF_RST_IND_A;
      bus_state_indicator_cfg_b <= `BPF_RST_IND_B;
      cfg_locked                <= 1'b0;
    end else if (cfg_wr && !cfg_locked) begin
      request_ready_pin_cfg     <= rr_cfg_in;
      carrier_detect_pin_cfg    <= cd_cfg_in;
      ring_indicator_pin_cfg    <= ri_cfg_in;
      serial_data_pin_cfg       <= sd_cfg_in;
      bus_state_indicator_cfg_a <= ind_a_cfg_in;
      bus_state_indicator_cfg_b <= ind_b_cfg_in;
      cfg_locked                <= 1'b1;
    end
  end

  // Synchronisers; a change counts once stages two and three agree
  always @(posedge sys_clk) begin
    if (srst) begin
      // Both pins idle high; a low reset value would fake a wake
      ri_sync   <= 3'h7;
      rx_sync   <= 3'h7;
      ri_stable <= 1'b1;
      rx_stable <= 1'b1;
    end else begin
      ri_sync <= {ri_sync[1:0], ri_pin_in};
      rx_sync <= {rx_sync[1:0], rx_pin_in};
      if (ri_sync[1] == ri_sync[2]) begin
        ri_stable <= ri_sync[2];
      end
      if (rx_sync[1] == rx_sync[2]) begin
        rx_stable <= rx_sync[2];
      end
    end
  end

  // Driver mode decode per pin
  reg rr_od_c, rr_pp_c, rr_lvl_c;
  reg cd_od_c, cd_pp_c;
  reg ri_od_c, ri_pp_c;
  reg sd_od_c, sd_pp_c;
  reg ia_od_c, ia_pp_c, ib_od_c, ib_pp_c;
  reg ind_a_c, ind_b_c;
  always @* begin
    rr_od_c  = 1'b0;
    rr_pp_c  = 1'b0;
    rr_lvl_c = rr_gpio_out;
    case (rr_fn)
      `BPF_RR_GPIO_OD: rr_od_c = 1'b1;
      `BPF_RR_GPIO_PP: rr_pp_c = 1'b1;
      `BPF_RR_DED_OD: begin
        rr_od_c  = 1'b1;
        rr_lvl_c = rr_ded_out;
      end
      `BPF_RR_DED_PP: begin
        rr_pp_c  = 1'b1;
        rr_lvl_c = rr_ded_out;
      end
      default: rr_lvl_c = rr_gpio_out;
    endcase
    // Carrier: 11 reserved falls to input
    cd_od_c = (cd_fn == `BPF_F2_OD);
    cd_pp_c = (cd_fn == `BPF_F2_PP);
    // Ring: 11 is the dedicated input
    ri_od_c = (ri_fn == `BPF_F2_OD);
    ri_pp_c = (ri_fn == `BPF_F2_PP);
    // Transmit: 00 and 11 reserved, pad stays input
    sd_od_c = (sd_fn == `BPF_F2_OD);
    sd_pp_c = (sd_fn == `BPF_F2_PP);
    ia_od_c = (bus_state_indicator_cfg_a[`BPF_FN2_MSB:0] == `BPF_F2_OD);
    ia_pp_c = (bus_state_indicator_cfg_a[`BPF_FN2_MSB:0] == `BPF_F2_PP);
    ib_od_c = (bus_state_indicator_cfg_b[`BPF_FN2_MSB:0] == `BPF_F2_OD);
    ib_pp_c = (bus_state_indicator_cfg_b[`BPF_FN2_MSB:0] == `BPF_F2_PP);
    // Indicator level; function field shared by both outputs
    case (indicator_function_sel)
      `BPF_IND_SUSP: ind_a_c = usb_suspend;
      `BPF_IND_SUSP_N: ind_a_c = ~usb_suspend;
      `BPF_IND_LOWP: ind_a_c = usb_suspend | ~usb_configured;
      `BPF_IND_LOWP_N: ind_a_c = ~(usb_suspend | ~usb_configured);
      `BPF_IND_BRST: ind_a_c = usb_bus_reset;
      `BPF_IND_BRST_N: ind_a_c = ~usb_bus_reset;
      default: ind_a_c = usb_suspend | usb_bus_reset;
    endcase
    if (indicator_function_sel == `BPF_IND_BOTH ||
        indicator_function_sel == `BPF_IND_BOTH_ALT) begin
      ind_b_c = ~(usb_suspend | usb_bus_reset);
    end else begin
      ind_b_c = ind_a_c;
    end
  end

  // Shared pad decode for every pin
  wire [7:0] pu_req = {request_ready_pin_cfg[`BPF_PULL_UP_BIT], carrier_detect_pin_cfg[`BPF_PULL_UP_BIT],
                       ring_indicator_pin_cfg[`BPF_PULL_UP_BIT], serial_data_pin_cfg[`BPF_PULL_UP_BIT],
                       bus_state_indicator_cfg_a[`BPF_PULL_UP_BIT], bus_state_indicator_cfg_b[`BPF_PULL_UP_BIT],
                       2'h0};
  wire [7:0] pd_req = {request_ready_pin_cfg[`BPF_PULL_DN_BIT], carrier_detect_pin_cfg[`BPF_PULL_DN_BIT],
                       ring_indicator_pin_cfg[`BPF_PULL_DN_BIT], serial_data_pin_cfg[`BPF_PULL_DN_BIT],
                       bus_state_indicator_cfg_a[`BPF_PULL_DN_BIT], bus_state_indicator_cfg_b[`BPF_PULL_DN_BIT],
                       2'h0};
  wire [7:0] od_v   = {rr_od_c, cd_od_c, ri_od_c, sd_od_c, ia_od_c, ib_od_c, 2'h0};
  wire [7:0] pp_v   = {rr_pp_c, cd_pp_c, ri_pp_c, sd_pp_c, ia_pp_c, ib_pp_c, 2'h0};
  wire [7:0] lvl_v  = {rr_lvl_c, cd_gpio_out, ri_gpio_out, tx_data, ind_a_c, ind_b_c, 2'h0};
  wire [7:0] pu_v, pd_v, out_v, oe_v;
  genvar gi;
  generate
    for (gi = 2; gi < 8; gi = gi + 1) begin : g_pad
      bpf_pad_ctl u_pad (
        .pull_up_req (pu_req[gi]),
        .pull_dn_req (pd_req[gi]),
        .drv_od      (od_v[gi]),
        .drv_pp      (pp_v[gi]),
        .out_level   (lvl_v[gi]),
        .pull_up_en  (pu_v[gi]),
        .pull_dn_en  (pd_v[gi]),
        .pad_out     (out_v[gi]),
        .pad_oe      (oe_v[gi])
      );
    end
  endgenerate
  assign pu_v[1:0]  = 2'h0;
  assign pd_v[1:0]  = 2'h0;
  assign out_v[1:0] = 2'h0;
  assign oe_v[1:0]  = 2'h0;

  // Register all pad controls and the wake request
  always @(posedge sys_clk) begin
    if (srst) begin
      rr_out <= 1'b0;  rr_oe <= 1'b0;  rr_pull <= 2'h0;  rr_ded_sel <= 1'b0;
      cd_out <= 1'b0;  cd_oe <= 1'b0;  cd_pull <= 2'h0;
      ri_out <= 1'b0;  ri_oe <= 1'b0;  ri_pull <= 2'h0;  ri_ded_sel <= 1'b0;
      tx_out <= 1'b1;  tx_oe <= 1'b0;  rx_pull <= 2'h0;
      bus_state_out_a <= 1'b0;  bus_state_out_a_oe <= 1'b0;
      bus_state_out_b <= 1'b0;  bus_state_out_b_oe <= 1'b0;
      remote_wake_req <= 1'b0;
    end else begin
      rr_out  <= out_v[7];
      rr_oe   <= oe_v[7];
      rr_pull <= {pu_v[7], pd_v[7]};
      rr_ded_sel <= (rr_fn == `BPF_RR_DED_OD) | (rr_fn == `BPF_RR_DED_PP);
      cd_out  <= out_v[6];
      cd_oe   <= oe_v[6];
      cd_pull <= {pu_v[6], pd_v[6]};
      ri_out  <= out_v[5];
      ri_oe   <= oe_v[5];
      ri_pull <= {pu_v[5], pd_v[5]};
      ri_ded_sel <= (ri_fn == `BPF_F2_DED);
      tx_out  <= out_v[4];
      tx_oe   <= oe_v[4];
      rx_pull <= {pu_v[4], pd_v[4]};
      bus_state_out_a    <= out_v[3];
      bus_state_out_a_oe <= oe_v[3];
      bus_state_out_b    <= out_v[2];
      bus_state_out_b_oe <= oe_v[2];
      // Wake on active-low ring or receive start bit while suspended
      remote_wake_req <= usb_suspend & usb_rwk_attr &
                         ((wake_from_pin_enable_ri & ~ri_stable) |
                          (wake_from_pin_enable_rx & ~rx_stable));
    end
  end
endmodule
`default_nettype wire

// [bpf_consts.vh]
// Purpose: constants for the bridge pin function configuration block
// Assumes: one 8-bit configuration byte per pin group
// Notes:   field positions, codes and default byte values
`ifndef BPF_CONSTS_VH
`define BPF_CONSTS_VH
// Common bit positions
`define BPF_PULL_UP_BIT     7
`define BPF_PULL_DN_BIT     6
`define BPF_WAKE_BIT        5
// Field positions
`define BPF_RR_FN_MSB       2
`define BPF_FN2_MSB         1
`define BPF_IND_FN_MSB      4
`define BPF_IND_FN_LSB      2
// Request/ready function codes
`define BPF_RR_GPIO_IN      3'h0
`define BPF_RR_GPIO_OD      3'h1
`define BPF_RR_GPIO_PP      3'h2
`define BPF_RR_DED_OD       3'h3
`define BPF_RR_DED_PP       3'h4
// Two-bit function codes
`define BPF_F2_GPIO_IN      2'h0
`define BPF_F2_OD           2'h1
`define BPF_F2_PP           2'h2
`define BPF_F2_DED          2'h3
// Indicator function codes
`define BPF_IND_BOTH        3'h0
`define BPF_IND_SUSP        3'h1
`define BPF_IND_LOWP        3'h2
`define BPF_IND_BRST        3'h3
`define BPF_IND_BOTH_ALT    3'h4
`define BPF_IND_SUSP_N      3'h5
`define BPF_IND_LOWP_N      3'h6
`define BPF_IND_BRST_N      3'h7
// Default bytes
`define BPF_RST_RR          8'h03
`define BPF_RST_CD          8'h00
`define BPF_RST_RI          8'h00
`define BPF_RST_SD          8'h02
`define BPF_RST_IND_A       8'h0A
`define BPF_RST_IND_B       8'h1A
`endif

// [bpf_pad_ctl.v]
// Purpose: per-pad decode of a pull request and a driver mode
// Assumes: same clock domain as the caller, purely combinational
// Notes:   reserved driver modes leave the pad as input
`timescale 1ns/10ps
`default_nettype none
module bpf_pad_ctl (
  input  wire       pull_up_req,  // Pull-up bit of the byte
  input  wire       pull_dn_req,  // Pull-down bit of the byte
  input  wire       drv_od,       // Open-drain output selected
  input  wire       drv_pp,       // Push-pull output selected
  input  wire       out_level,    // Level the pad should show
  output wire       pull_up_en,   // Pull-up resistor enable
  output wire       pull_dn_en,   // Pull-down resistor enable
  output wire       pad_out,      // Pad output value
  output wire       pad_oe        // Pad output enable, high drives
);
  // Pull-up wins over pull-down
  assign pull_up_en = pull_up_req;
  assign pull_dn_en = pull_dn_req & ~pull_up_req;
  // Open drain only drives the low level
  assign pad_out = drv_pp ? out_level : 1'b0;
  assign pad_oe  = drv_pp | (drv_od & ~out_level);
endmodule
`default_nettype wire

// [bpf_pin_cfg_assertions.sv]
// Purpose: Assertion checker for the pin configuration block
// Assumes: Stored bytes steady once locked, pad decode one cycle late
// Notes:   Bound to the block by the statement at the foot
`timescale 1ns/10ps
`default_nettype none
module bpf_pin_cfg_chk (
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       cfg_wr,
  input wire logic [7:0] rr_cfg_in,
  input wire logic       usb_suspend,
  input wire logic       tx_data,
  input wire logic [7:0] request_ready_pin_cfg,
  input wire logic [7:0] carrier_detect_pin_cfg,
  input wire logic [7:0] ring_indicator_pin_cfg,
  input wire logic [7:0] serial_data_pin_cfg,
  input wire logic [7:0] bus_state_indicator_cfg_a,
  input wire logic       cfg_locked,
  input wire logic       rr_oe,
  input wire logic [1:0] rr_pull,
  input wire logic       rr_ded_sel,
  input wire logic       cd_oe,
  input wire logic       ri_ded_sel,
  input wire logic       tx_out,
  input wire logic       tx_oe,
  input wire logic       bus_state_out_a
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Strobe that the block must take: nothing locked yet
  sequence s_take;
    cfg_wr && !cfg_locked;
  endsequence
  // Decode is judged only once the bytes can no longer move
  sequence s_set;
    cfg_locked;
  endsequence
  AST_TAKE: assert property (s_take |=> cfg_locked && request_ready_pin_cfg == $past(rr_cfg_in))
    else $error("Write not taken");
  AST_HOLD: assert property (s_set |=> cfg_locked && $stable(request_ready_pin_cfg))
    else $error("Locked byte changed");
  AST_PULL: assert property (s_set |=> rr_pull ==
    {$past(request_ready_pin_cfg[7]), $past(request_ready_pin_cfg[6]) && !$past(request_ready_pin_cfg[7])})
    else $error("Pull decode wrong");
  AST_RR_RSV: assert property (s_set ##0 request_ready_pin_cfg[2:0] > 3'h4 |=> !rr_oe)
    else $error("Reserved request code drives");
  AST_RR_DED: assert property (s_set |=> rr_ded_sel == ($past(request_ready_pin_cfg[2:0]) inside {3'h3, 3'h4}))
    else $error("Dedicated request select wrong");
  AST_CD_RSV: assert property (s_set ##0 carrier_detect_pin_cfg[1:0] == 2'h3 |=> !cd_oe)
    else $error("Reserved carrier code drives");
  AST_RI_DED: assert property (s_set |=> ri_ded_sel == ($past(ring_indicator_pin_cfg[1:0]) == 2'h3))
    else $error("Ring select wrong");
  AST_TX_PP: assert property (s_set ##0 serial_data_pin_cfg[1:0] == 2'h2 |=> tx_oe && tx_out == $past(tx_data))
    else $error("Push-pull transmit wrong");
  AST_TX_RSV: assert property (s_set ##0 serial_data_pin_cfg[1:0] inside {2'h0, 2'h3} |=> !tx_oe)
    else $error("Reserved transmit code drives");
  AST_IND_SUSP: assert property (s_set ##0 bus_state_indicator_cfg_a[4:0] == 5'h06
    |=> bus_state_out_a == $past(usb_suspend))
    else $error("Suspend indicator wrong");
endmodule
bind bpf_pin_cfg bpf_pin_cfg_chk u_bpf_pin_cfg_chk (.sys_clk, .srst, .cfg_wr, .rr_cfg_in, .usb_suspend, .tx_data,
  .request_ready_pin_cfg, .carrier_detect_pin_cfg, .ring_indicator_pin_cfg, .serial_data_pin_cfg,
  .bus_state_indicator_cfg_a, .cfg_locked, .rr_oe, .rr_pull, .rr_ded_sel, .cd_oe, .ri_ded_sel, .tx_out, .tx_oe,
  .bus_state_out_a);
`default_nettype wire

// [bpf_host_model.sv]
// Purpose: Host side that sends the one pin configuration set
// Assumes: Strobe launched just after a rising edge
// Notes:   Bytes are scrambled once the strobe drops
`timescale 1ns/10ps
`default_nettype none
module bpf_host_model (
  input  wire logic       sys_clk,
  output var  logic       cfg_wr,
  output var  logic [47:0] cfg_bytes  // Request, carrier, ring, serial, A, B
);
  initial begin
    cfg_wr    = 1'b0;
    cfg_bytes = 48'h0;
  end
  // Reserved request codes are strobed only when a test asks for them
  task automatic send(input logic [47:0] b);
    @(posedge sys_clk);
    #1 cfg_wr = 1'b1;
    cfg_bytes = b;
    @(posedge sys_clk);
    #1 cfg_wr = 1'b0;
    cfg_bytes = ~b;  // Stale bytes must not look valid
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the pin configuration block
// Assumes: Pads and pulls settle two edges after a change
// Notes:   Each pass resets, writes, sweeps bus states, then checks a second write is ignored
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic sys_clk, srst, cfg_wr, usb_suspend, usb_configured, usb_bus_reset, usb_rwk_attr;
  logic rr_gpio_out, rr_ded_out, cd_gpio_out, ri_gpio_out, ri_pin_in, rx_pin_in, tx_data;
  logic [47:0] cfg_bytes;
  logic [7:0] request_ready_pin_cfg, carrier_detect_pin_cfg, ring_indicator_pin_cfg, serial_data_pin_cfg;
  logic [7:0] bus_state_indicator_cfg_a, bus_state_indicator_cfg_b;
  logic cfg_locked, rr_out, rr_oe, rr_ded_sel, cd_out, cd_oe, ri_out, ri_oe, ri_ded_sel, tx_out, tx_oe;
  logic bus_state_out_a, bus_state_out_a_oe, bus_state_out_b, bus_state_out_b_oe, remote_wake_req;
  logic [1:0] rr_pull, cd_pull, ri_pull, rx_pull, e;
  int n_fail, checked, i, j;
  bpf_host_model u_bpf_host_model (.sys_clk, .cfg_wr, .cfg_bytes);
  bpf_pin_cfg u_bpf_pin_cfg (.sys_clk, .srst, .cfg_wr, .rr_cfg_in(cfg_bytes[47:40]), .cd_cfg_in(cfg_bytes[39:32]),
    .ri_cfg_in(cfg_bytes[31:24]), .sd_cfg_in(cfg_bytes[23:16]), .ind_a_cfg_in(cfg_bytes[15:8]),
    .ind_b_cfg_in(cfg_bytes[7:0]), .usb_suspend, .usb_configured, .usb_bus_reset, .usb_rwk_attr, .rr_gpio_out,
    .rr_ded_out, .cd_gpio_out, .ri_gpio_out, .ri_pin_in, .rx_pin_in, .tx_data, .request_ready_pin_cfg,
    .carrier_detect_pin_cfg, .ring_indicator_pin_cfg, .serial_data_pin_cfg, .bus_state_indicator_cfg_a,
    .bus_state_indicator_cfg_b, .cfg_locked, .rr_out, .rr_oe, .rr_pull, .rr_ded_sel, .cd_out, .cd_oe, .cd_pull,
    .ri_out, .ri_oe, .ri_pull, .ri_ded_sel, .tx_out, .tx_oe, .rx_pull, .bus_state_out_a, .bus_state_out_a_oe,
    .bus_state_out_b, .bus_state_out_b_oe, .remote_wake_req);
  // 10 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  // Bounded wait: the pin synchroniser adds a few cycles
  task automatic wake_is(input logic v);
    for (int k = 0; k < 8 && remote_wake_req !== v; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(8'(remote_wake_req), 8'(v));
  endtask
  // Expected {A, B} levels; only codes 000/100 split the pair
  function automatic logic [1:0] ind_exp(input logic [2:0] f, input logic s, input logic r, input logic c);
    logic l;
    case (f[1:0])
      2'h0: l = s | r;
      2'h1: l = s;
      2'h2: l = s | ~c;
      default: l = r;
    endcase
    if (f[1:0] == 2'h0) return {l, ~l};
    return {2{l ^ f[2]}};
  endfunction
  task automatic end_of_test();
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    {srst, usb_suspend, usb_configured, usb_bus_reset, usb_rwk_attr} = 5'h10;
    {rr_gpio_out, rr_ded_out, cd_gpio_out, ri_gpio_out, ri_pin_in, rx_pin_in, tx_data} = 7'h2E;
    repeat (20) @(posedge sys_clk);
    #1 srst = 1'b0;
    settle();
    chk(request_ready_pin_cfg, 8'h03);
    chk(8'(rr_ded_sel), 8'h01);
    chk(8'(bus_state_out_a), 8'h01);
    for (i = 0; i < 8; i++) begin
      srst = 1'b1;
      @(posedge sys_clk);
      #1 srst = 1'b0;
      u_bpf_host_model.send({i[1:0], 3'h0, i[2:0], i[1:0], 4'h0, i[1:0], 8'h20 | 8'(i[1:0]),
        i[1:0], 4'h8, i[1:0], i[1:0], 1'h0, i[2:0], 2'h2, 8'h01});
      settle();
      e = {i[1], i[0] & ~i[1]};
      chk(8'(rr_oe), 8'(i inside {1, 2, 4}));
      chk(8'(rr_out), 8'(i == 4));
      chk(8'(rr_ded_sel), 8'(i inside {3, 4}));
      chk(8'(rr_pull), 8'(e));
      chk(8'(cd_pull), 8'(e));
      chk(8'(ri_pull), 8'h00);
      chk(8'({ri_oe, ri_out}), 8'({2{i[1:0] == 2'h2}}));
      chk(8'(tx_out), 8'h00);
      chk(8'(rx_pull), 8'(e));
      chk(8'(cd_oe), 8'(i[1:0] inside {2'h1, 2'h2}));
      chk(8'(ri_ded_sel), 8'(i[1:0] == 2'h3));
      chk(8'(tx_oe), 8'(i[1:0] inside {2'h1, 2'h2}));
      for (j = 0; j < 8; j++) begin
        {usb_suspend, usb_bus_reset, usb_configured} = j[2:0];
        settle();
        e = ind_exp(i[2:0], j[2], j[1], j[0]);
        chk(8'({bus_state_out_a_oe, bus_state_out_a}), 8'({1'b1, e[1]}));
        chk(8'({bus_state_out_b_oe, bus_state_out_b & bus_state_out_b_oe}), 8'({~e[0], 1'b0}));
      end
      u_bpf_host_model.send(48'h0);
      settle();
      chk(request_ready_pin_cfg, {i[1:0], 3'h0, i[2:0]});
      chk(carrier_detect_pin_cfg, {i[1:0], 4'h0, i[1:0]});
      chk(ring_indicator_pin_cfg, 8'h20 | 8'(i[1:0]));
      chk(serial_data_pin_cfg, {i[1:0], 4'h8, i[1:0]});
      chk(bus_state_indicator_cfg_a, {i[1:0], 1'h0, i[2:0], 2'h2});
      chk(bus_state_indicator_cfg_b, 8'h01);
      chk(8'(cfg_locked), 8'h01);
    end
    {usb_suspend, usb_rwk_attr, ri_pin_in} = 3'h6;
    wake_is(1'b1);
    ri_pin_in = 1'b1;
    wake_is(1'b0);
    rx_pin_in = 1'b0;
    wake_is(1'b1);
    usb_rwk_attr = 1'b0;
    wake_is(1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
